/* File: hdl/tmr_regs.svh */
// Constants and mode encodings for the multimode timer.
// Behaviour
// - One-shot counts prescaled system clock ticks.
// - One-shot period is (reload minus start plus one) times prescale.
// - Enable write starts counting from loaded value.
// - Continuous mode counts up toward 16-bit reload.
// - Continuous reload raises request, count to 0001.
// - Continuous output toggles at every reload.
// - PWM polarity one: high idle, low match.
// - Capture edge rising for zero, falling for one.
// - Compare output follows polarity, inverts at reload.
// - Gated counts on input level, request on end.
// - Capture/compare starts at first edge, captures later.
// - Request flag reads one while request pending.
// - Prescaler divides by two to select; clears disabled.
// - Alternate function drives polarity level when idle.
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH
`define TMR_MODE_ONESHOT 3'h0
`define TMR_MODE_CONT 3'h1
`define TMR_MODE_COUNTER 3'h2
`define TMR_MODE_PWM 3'h3
`define TMR_MODE_CAPTURE 3'h4
`define TMR_MODE_COMPARE 3'h5
`define TMR_MODE_GATED 3'h6
`define TMR_MODE_CAPCMP 3'h7
`define TMR_COUNT_RESTART 16'h0001
`define TMR_COUNT_RESET 16'h0000
`define TMR_RELOAD_RESET 16'h0000
`define TMR_PRESC_RESET 7'h00
`define TMR_PRESC_ONE 7'h01
`define TMR_PRESC_ALL 7'h7f
`endif

/* File: hdl/tmr_pkg.sv */
// Types shared by the multimode timer files.
package tmr_pkg;
  // Counting modes, binary codes as selected on the mode port.
  typedef enum logic [2:0]
  {
    MODE_ONESHOT = 3'b000,
    MODE_CONT = 3'b001,
    MODE_COUNTER = 3'b010,
    MODE_PWM = 3'b011,
    MODE_CAPTURE = 3'b100,
    MODE_COMPARE = 3'b101,
    MODE_GATED = 3'b110,
    MODE_CAPCMP = 3'b111
  } mode_t;
  // Run state of the counter.
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_WAIT_EDGE = 2'b01,
    ST_RUN = 2'b10
  } run_t;
endpackage

/* File: hdl/tmr_sync.sv */
// Three-stage synchroniser with agreement filter for the timer input pin.
`timescale 1ns/1ps
module tmr_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  // First stage, read only by the second stage.
  logic s1_q;
  // Second and third stages, compared to accept a change.
  logic s2_q;
  logic s3_q;

  // Shift the pin through the three stages.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new level once the second and third stages agree.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dout <= 1'b0;
    end
    else if (s2_q == s3_q)
    begin
      dout <= s3_q;
    end
  end
endmodule

/* File: hdl/multimode_timer_counter.sv */
// Sixteen-bit multimode timer with prescaler, capture and output pin.
`timescale 1ns/1ps
`include "tmr_regs.svh"
module multimode_timer_counter
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic TMR_ENABLE,
  input wire logic [2:0] TMR_MODE,
  input wire logic [2:0] PRESCALE_SELECT,
  input wire logic OUTPUT_POLARITY_BIT,
  input wire logic COUNT_WR,
  input wire logic [15:0] COUNT_WDATA,
  input wire logic [15:0] RELOAD_VALUE,
  input wire logic [15:0] PWM_VALUE,
  input wire logic ALT_FUNC_EN,
  input wire logic TIMER_INPUT_PIN,
  input wire logic REQUEST_CLR,
  output logic TIMER_OUTPUT_PIN,
  output logic TIMER_REQUEST_FLAG,
  output logic [15:0] COUNT_VALUE,
  output logic [15:0] CAPTURE_VALUE,
  output logic CAPTURE_EVENT,
  output logic RUNNING
);
  default clocking sample_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ////////////////////////////////////////////////////////////////////////////
  // Filtered input level and its previous value.
  logic in_lvl;
  logic in_prev_q;
  // Edge of the selected polarity on the input.
  logic act_edge;
  // Opposite edge, which ends a gated window.
  logic end_edge;
  // Prescaler counter and the tick it produces.
  logic [6:0] presc_q;
  logic tick;
  logic [6:0] presc_mask;
  // Counter and its run state.
  logic [15:0] count_q;
  tmr_pkg::run_t run_q;
  // Enable seen in previous cycle, to find the enabling write.
  logic en_prev_q;
  // Internal self-clear of the enable after a one-shot.
  logic oneshot_done_q;
  logic active;
  // Reload and match events on this tick.
  logic reload_hit;
  logic pwm_hit;
  logic gate_ok;
  logic out_q;
  logic in_gated;
  tmr_pkg::mode_t mode;

  assign mode = tmr_pkg::mode_t'(TMR_MODE);

  // Synchronise the timer input pin.
  tmr_sync u_sync
  (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .din(TIMER_INPUT_PIN),
    .dout(in_lvl)
  );

  // Remember last input level for edge detection.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      in_prev_q <= 1'b0;
    else
      in_prev_q <= in_lvl;
  end

  // Rising edge for polarity zero, falling for one.
  assign act_edge = (in_lvl ^ in_prev_q) &
                    (in_lvl ^ OUTPUT_POLARITY_BIT);
  assign end_edge = (in_lvl ^ in_prev_q) &
                    ~(in_lvl ^ OUTPUT_POLARITY_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Enable and run state.
  ////////////////////////////////////////////////////////////////////////////
  // The timer runs while enabled and not stopped by a finished one-shot.
  assign active = TMR_ENABLE & ~oneshot_done_q;
  assign RUNNING = active;

  // Track the enable and the one-shot completion stop.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      en_prev_q <= 1'b0;
      oneshot_done_q <= 1'b0;
    end
    else
    begin
      en_prev_q <= TMR_ENABLE;
      if (!TMR_ENABLE)
      begin
        // A disable re-arms the one-shot stop.
        oneshot_done_q <= 1'b0;
      end
      else if (mode == tmr_pkg::MODE_ONESHOT && tick && reload_hit &&
               run_q == tmr_pkg::ST_RUN)
      begin
        oneshot_done_q <= 1'b1;
      end
    end
  end

  // Run state machine: capture/compare waits for its first edge.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      run_q <= tmr_pkg::ST_IDLE;
    end
    else
    begin
      case (run_q)
        tmr_pkg::ST_IDLE:
        begin
          // Start on the enabling write.
          if (active && !en_prev_q)
          begin
            if (mode == tmr_pkg::MODE_CAPCMP)
            begin
              run_q <= tmr_pkg::ST_WAIT_EDGE;
            end
            else
            begin
              run_q <= tmr_pkg::ST_RUN;
            end
          end
        end
        tmr_pkg::ST_WAIT_EDGE:
        begin
          if (!active)
          begin
            run_q <= tmr_pkg::ST_IDLE;
          end
          else if (act_edge)
          begin
            run_q <= tmr_pkg::ST_RUN;
          end
        end
        tmr_pkg::ST_RUN:
        begin
          if (!active)
            run_q <= tmr_pkg::ST_IDLE;
        end
        default:
          run_q <= tmr_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler.
  ////////////////////////////////////////////////////////////////////////////
  // Mask of low bits that must all be set for a tick.
  assign presc_mask = 7'(`TMR_PRESC_ALL >> (3'h7 - PRESCALE_SELECT));

  // Divide the system clock by two to the prescale select.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      presc_q <= `TMR_PRESC_RESET;
    else if (run_q != tmr_pkg::ST_RUN || !active)
      presc_q <= `TMR_PRESC_RESET;
    else if (tick)
      presc_q <= `TMR_PRESC_RESET;
    else
      presc_q <= 7'(presc_q + `TMR_PRESC_ONE);
  end

  assign tick = active && run_q == tmr_pkg::ST_RUN &&
                ((presc_q & presc_mask) == presc_mask);

  // Gated mode advances only during the selected input level.
  assign in_gated = in_lvl ^ OUTPUT_POLARITY_BIT;
  assign gate_ok = (mode != tmr_pkg::MODE_GATED) | in_gated;
  assign reload_hit = (count_q == RELOAD_VALUE);
  assign pwm_hit = (count_q == PWM_VALUE);

  ////////////////////////////////////////////////////////////////////////////
  // Counter.
  ////////////////////////////////////////////////////////////////////////////
  // Count up toward reload, restart at one on reload.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      count_q <= `TMR_COUNT_RESET;
    end
    else if (COUNT_WR && !active)
    begin
      count_q <= COUNT_WDATA;
    end
    else if (tick && gate_ok)
    begin
      if (reload_hit)
      begin
        count_q <= `TMR_COUNT_RESTART;
      end
      else
      begin
        count_q <= 16'(count_q + 16'h0001);
      end
    end
  end
  assign COUNT_VALUE = count_q;

  // Latch the count on capture edges.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      CAPTURE_VALUE <= `TMR_COUNT_RESET;
      CAPTURE_EVENT <= 1'b0;
    end
    else
    begin
      CAPTURE_EVENT <= 1'b0;
      if (active && run_q == tmr_pkg::ST_RUN && act_edge &&
          (mode == tmr_pkg::MODE_CAPTURE || mode == tmr_pkg::MODE_CAPCMP))
      begin
        CAPTURE_VALUE <= count_q;
        CAPTURE_EVENT <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flag.
  ////////////////////////////////////////////////////////////////////////////
  // Sticky request: reload, gated end edge or capture sets; set beats clear.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      TIMER_REQUEST_FLAG <= 1'b0;
    end
    else if ((tick && gate_ok && reload_hit) ||
             (active && run_q == tmr_pkg::ST_RUN && act_edge &&
              (mode == tmr_pkg::MODE_CAPTURE ||
               mode == tmr_pkg::MODE_CAPCMP)) ||
             (active && mode == tmr_pkg::MODE_GATED && end_edge))
    begin
      TIMER_REQUEST_FLAG <= 1'b1;
    end
    else if (REQUEST_CLR)
    begin
      TIMER_REQUEST_FLAG <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin.
  ////////////////////////////////////////////////////////////////////////////
  // Idle takes polarity; running toggles or follows PWM match and reload.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      out_q <= 1'b0;
    end
    else if (!active)
    begin
      out_q <= OUTPUT_POLARITY_BIT;
    end
    else if (tick && gate_ok)
    begin
      if (reload_hit)
      begin
        if (mode == tmr_pkg::MODE_PWM)
        begin
          out_q <= OUTPUT_POLARITY_BIT;
        end
        else
        begin
          out_q <= ~out_q;
        end
      end
      else if (mode == tmr_pkg::MODE_PWM && pwm_hit)
      begin
        out_q <= ~OUTPUT_POLARITY_BIT;
      end
    end
  end
  // Pin shows the timer level only with the alternate function on.
  assign TIMER_OUTPUT_PIN = ALT_FUNC_EN & out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  ////////////////////////////////////////////////////////////////////////////
  chk_cont_restart: assert property (
    (tick && gate_ok && reload_hit) |=> (count_q == `TMR_COUNT_RESTART))
    else $error("count did not restart at one");
  chk_req_set: assert property (
    (tick && gate_ok && reload_hit) |=> TIMER_REQUEST_FLAG)
    else $error("request flag not set on reload");
  chk_idle_polarity: assert property (
    (!active && ALT_FUNC_EN) |=>
    (!ALT_FUNC_EN || TIMER_OUTPUT_PIN == $past(OUTPUT_POLARITY_BIT)))
    else $error("idle output differs from polarity");
  chk_toggle: assert property (
    (active && tick && reload_hit && mode == tmr_pkg::MODE_CONT) |=>
    (out_q != $past(out_q)))
    else $error("output did not toggle at reload");
  chk_oneshot_stop: assert property (
    (TMR_ENABLE && mode == tmr_pkg::MODE_ONESHOT && tick && reload_hit) |=>
    (!active || !$past(TMR_ENABLE)) [*2])
    else $error("one-shot kept running");
  chk_presc_clear: assert property (
    !active |=> (presc_q == `TMR_PRESC_RESET))
    else $error("prescaler not cleared while disabled");
  chk_capture: assert property (
    (active && run_q == tmr_pkg::ST_RUN && act_edge &&
    mode == tmr_pkg::MODE_CAPTURE) |=>
    (CAPTURE_EVENT && CAPTURE_VALUE == $past(count_q)))
    else $error("capture missed edge");
  chk_gate_hold: assert property (
    (mode == tmr_pkg::MODE_GATED && !in_gated && !COUNT_WR) |=>
    $stable(count_q))
    else $error("gated counter advanced outside gate");
  chk_pwm_match: assert property (
    (active && tick && mode == tmr_pkg::MODE_PWM && pwm_hit && !reload_hit)
    |=> (out_q == ~$past(OUTPUT_POLARITY_BIT)))
    else $error("pwm match level wrong");
endmodule

/* File: test/tmr_pin_model.sv */
// Far-side model that drives the timer input pin.
`timescale 1ns/1ps
module tmr_pin_model
(
  input wire logic clk,
  input wire logic level,
  output logic pin
);
  // The pin follows the requested level 7 ns after a rising edge.
  // Its edges then never line up with the sampling edge of the timer.
  always @(posedge clk)
  begin
    pin <= #7 level;
  end
  // The pin starts low so the synchroniser sees a known level.
  initial
  begin
    pin = 1'b0;
  end
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the multimode timer.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0, wr = 1'b0, clr = 1'b0, alt = 1'b0;
  logic pol = 1'b0, lvl = 1'b0, pin;
  logic [2:0] mode = 3'h0, pre = 3'h0;
  logic [15:0] wdat = 16'h0000, rel = 16'h0000, pwm = 16'h0000;
  logic tout, flag, cev, run;
  logic [15:0] cnt, cap;
  logic [15:0] notes[$]; // Counts noted when an active edge is driven.
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  multimode_timer_counter u_dut
  (
    .CORE_CLK(clk), .RST_N(rst_n), .TMR_ENABLE(en), .TMR_MODE(mode),
    .PRESCALE_SELECT(pre), .OUTPUT_POLARITY_BIT(pol), .COUNT_WR(wr),
    .COUNT_WDATA(wdat), .RELOAD_VALUE(rel), .PWM_VALUE(pwm),
    .ALT_FUNC_EN(alt), .TIMER_INPUT_PIN(pin), .REQUEST_CLR(clr),
    .TIMER_OUTPUT_PIN(tout), .TIMER_REQUEST_FLAG(flag),
    .COUNT_VALUE(cnt), .CAPTURE_VALUE(cap), .CAPTURE_EVENT(cev),
    .RUNNING(run)
  );
  tmr_pin_model u_pin
  (
    .clk(clk), .level(lvl), .pin(pin)
  );
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Counts one comparison and reports it when it does not hold.
  task automatic chk(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Waits n edges, then steps 2 ns past the last one.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Loads the start count while stopped, then enables in one step.
  task automatic arm(input logic [2:0] m, input logic [2:0] p,
    input logic pl, input logic [15:0] s, input logic [15:0] r);
    en = 1'b0;
    mode = m;
    pre = p;
    pol = pl;
    wdat = s;
    rel = r;
    wr = 1'b1;
    clr = 1'b1;
    cyc(1);
    wr = 1'b0;
    clr = 1'b0;
    en = 1'b1;
    cyc(1);
  endtask
  // Waits a bounded time for the request flag; returns cycles waited.
  task automatic wflag(output int k);
    k = 0;
    while (flag !== 1'b1 && k < 5000)
    begin
      cyc(1);
      k++;
    end
    chk(flag === 1'b1, "request flag never set");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Each capture pulse takes the oldest note; the latch must trail it
  // by the input synchroniser delay only.
  always @(negedge clk)
  begin
    if (cev === 1'b1)
    begin
      if (notes.size() == 0)
        chk(1'b0, "capture without active edge");
      else
        chk(cap - notes.pop_front() inside {[2:10]}, "capture");
    end
  end
  // Cuts a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin : main
    int k;
    int j;
    logic o;
    logic [15:0] c;
    logic [15:0] r;
    logic [2:0] p;
    void'($urandom(46068));
    cyc(2);
    rst_n = 1'b1;
    chk(flag === 1'b0 && cnt === 16'h0000 && run === 1'b0, "reset");
    // Idle output level for every mode and polarity.
    for (int m = 0; m < 8; m++)
      for (int pl = 0; pl < 2; pl++)
      begin
        mode = m[2:0];
        pol = pl[0];
        alt = 1'b1;
        cyc(2);
        chk(tout === pl[0], "idle level");
        alt = 1'b0;
        cyc(1);
        chk(tout === 1'b0, "pin not gated");
      end
    alt = 1'b1;
    // Continuous and compare: reload period, restart value, toggling.
    for (int i = 0; i < 2; i++)
    begin
      p = 3'($urandom_range(2));
      r = 16'($urandom_range(4, 20));
      arm(i ? 3'h5 : 3'h1, p, 1'($urandom), 16'h0000, r);
      wflag(k);
      chk(cnt === 16'h0001, "restart count");
      cyc(2);
      o = tout;
      wr = 1'b1;
      wdat = 16'hffff;
      clr = 1'b1;
      cyc(1);
      wr = 1'b0;
      clr = 1'b0;
      chk(cnt < 16'hffff && flag === 1'b0, "load while active");
      wflag(k);
      j = (int'(r) - 1) << p;
      chk(k + 3 >= j && k <= (int'(r) << p) + 1, "period");
      cyc(2);
      chk(tout === ~o, "toggle at reload");
    end
    // One-shot: time-out, then stop with count held.
    arm(3'h0, 3'h0, 1'b0, 16'h0003, 16'h0009);
    pol = 1'b1;
    wflag(k);
    chk(k + 2 >= 6 && k <= 9, "one-shot period");
    cyc(2);
    chk(run === 1'b0, "one-shot stop");
    cyc(5);
    chk(cnt === 16'h0001, "one-shot count held");
    // PWM both polarities.
    pwm = 16'h0014;
    for (int pl = 0; pl < 2; pl++)
    begin
      arm(3'h3, 3'h0, pl[0], 16'h0000, 16'h0028);
      k = 0;
      while (cnt !== pwm && k < 100)
      begin
        cyc(1);
        k++;
      end
      cyc(3);
      chk(tout === ~pl[0], "pwm match level");
      wflag(k);
      cyc(2);
      chk(tout === pl[0], "pwm reload level");
    end
    // Capture, gated and capture/compare, both polarities.
    for (int pl = 0; pl < 2; pl++)
    begin
      lvl = pl[0];
      cyc(10);
      arm(3'h4, 3'h0, pl[0], 16'h0000, 16'hff00);
      repeat (2)
      begin
        lvl = ~pl[0];
        notes.push_back(cnt);
        cyc(20);
        lvl = pl[0];
        cyc(20);
      end
      chk(flag === 1'b1, "capture request");
      arm(3'h6, 3'h0, pl[0], 16'h0000, 16'hffff);
      cyc(10);
      c = cnt;
      cyc(10);
      chk(cnt === c, "gate closed");
      lvl = ~pl[0];
      cyc(20);
      chk(cnt > c + 16'h000a && flag === 1'b0, "gate open");
      lvl = pl[0];
      cyc(10);
      chk(flag === 1'b1, "gate end request");
      arm(3'h7, 3'h0, pl[0], 16'h0000, 16'hffff);
      cyc(10);
      chk(cnt === 16'h0000, "waits for edge");
      lvl = ~pl[0];
      cyc(20);
      lvl = pl[0];
      chk(cnt > 16'h0000, "started at edge");
      cyc(20);
      lvl = ~pl[0];
      notes.push_back(cnt);
      cyc(20);
    end
    chk(notes.size() == 0, "captures missing");
    stop_test();
  end
endmodule
